// ---- core/eia_top.sv ----
// Purpose: exception control, request latching and priority arbitration
// Assumes: cpu strobes come from logic on pclk; irq pin is asynchronous
// Notes:   status registers are read-only views of live requests
//
// Overview of operation
// - stack registers, then set the global mask
// - return instruction unstacks saved registers
// - latch requests, arbitrate once, give vector code
// - latched request is not pre-empted
// - requests are taken only at instruction end
// - take hardware request if unmasked and enabled
// - highest priority pending request served first
// - still pending request served right after return
// - high index register is never stacked
// - software trap is taken regardless of mask
// - software trap stacks pc, hardware pc minus one
// - global mask gates all but software trap
// - shared level is OR of each group flag ANDed with its enable, plus that level's own hw_flag ANDed with hw_en
// - status flag reads one while request present
// - status one bits 0 and 1 read zero
// - reset has top priority, never arbitrated
// - status two holds levels 14 down to 7
//
// The implementer's own choices: the address map and the APB slave port.
module eia_top
   import eia_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 irq_pin_n,
   input  wire logic                 irq_pin_en,
   input  wire logic [NUM_LVL-2:0]   hw_flag,
   input  wire logic [NUM_LVL-2:0]   hw_en,
   input  wire logic [SPI_GRP-1:0]   spi_grp_flag,
   input  wire logic [SPI_GRP-1:0]   spi_grp_en,
   input  wire logic [SCI_GRP-1:0]   sci_grp_flag,
   input  wire logic [SCI_GRP-1:0]   sci_grp_en,
   input  wire eia_cpu_in_t          cpu_in,
   output eia_cpu_out_t              cpu_out,
   output logic                      stack_h,
   output logic                      irq
);
   logic               pin_s1_reg;
   logic               pin_s2_reg;
   eia_state_t         state_reg;
   eia_state_t         state_next;
   eia_cpu_out_t       out_reg;
   eia_cpu_out_t       out_next;
   logic [4:0]         lat_code_reg;
   logic [4:0]         lat_code_next;
   logic               lat_pcm1_reg;
   logic               lat_pcm1_next;
   logic [EVT_W-1:0]   evt_reg;
   logic [EVT_W-1:0]   evt_next;
   logic [EVT_W-1:0]   evt_set;
   logic [EVT_W-1:0]   mask_reg;
   logic [31:0]        prdata_reg;
   logic               pready_reg;
   logic               pslverr_reg;
   logic               irq_reg;
   logic               stack_h_reg;

   wire logic [NUM_LVL-1:0] grp_vec;
   wire logic [NUM_LVL-1:0] lvl_req;
   wire logic               hw_valid;
   wire logic [4:0]         hw_idx;
   wire logic               run_bnd;
   wire logic               take_swi;
   wire logic               take_hw;
   wire logic               setup;
   wire logic               access_done;
   wire logic               wr_done;
   wire logic               rd_done;
   wire logic               addr_ok;
   wire logic [31:0]        rd_mux;

   // irq pin synchroniser, second stage only is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
      end else begin
         pin_s1_reg <= irq_pin_n;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // shared levels: each flag gated by its own enable
   assign grp_vec = (NUM_LVL'(|(spi_grp_flag & spi_grp_en)) << SPI_LVL_IDX)
                  | (NUM_LVL'(|(sci_grp_flag & sci_grp_en)) << SCI_LVL_IDX);
   assign lvl_req = {hw_flag & hw_en, ~pin_s2_reg & irq_pin_en} | grp_vec;

   eia_prio_enc #(
      .N  (NUM_LVL),
      .IW (5)
   ) u_enc (
      .req   (lvl_req),
      .valid (hw_valid),
      .idx   (hw_idx)
   );

   assign run_bnd  = (state_reg == ST_RUN) && cpu_in.instr_done;
   assign take_swi = run_bnd && cpu_in.swi_exec;
   assign take_hw  = run_bnd && !cpu_in.swi_exec && !cpu_in.i_mask
                   && hw_valid;

   // exception sequencer
   always_comb begin
      state_next          = state_reg;
      out_next            = out_reg;
      out_next.set_imask  = 1'b0;
      out_next.vec_fetch  = 1'b0;
      out_next.unstack_req = 1'b0;
      lat_code_next       = lat_code_reg;
      lat_pcm1_next       = lat_pcm1_reg;
      evt_set             = '0;
      case (state_reg)
         ST_RESET_VEC: begin
            out_next.vec_fetch = 1'b1;
            out_next.vec_code  = CODE_RESET;
            out_next.vec_addr  = eia_vec_addr(CODE_RESET);
            state_next         = ST_RUN;
         end
         ST_RUN: begin
            if (take_swi) begin
               lat_code_next      = CODE_SWI;
               lat_pcm1_next      = 1'b0;
               out_next.stack_req = 1'b1;
               out_next.pc_minus1 = 1'b0;
               out_next.vec_code  = CODE_SWI;
               evt_set[EVT_SWI]   = 1'b1;
               state_next         = ST_STACK;
            end else if (take_hw) begin
               lat_code_next      = hw_idx + CODE_LVL1;
               lat_pcm1_next      = 1'b1;
               out_next.stack_req = 1'b1;
               out_next.pc_minus1 = 1'b1;
               out_next.vec_code  = hw_idx + CODE_LVL1;
               evt_set[EVT_HW]    = 1'b1;
               state_next         = ST_STACK;
            end else if (cpu_in.rti_exec) begin
               out_next.unstack_req = 1'b1;
               evt_set[EVT_RTI]     = 1'b1;
               state_next           = ST_UNSTACK;
            end
         end
         ST_STACK: begin
            // latched code held, no re-arbitration here
            out_next.vec_code  = lat_code_reg;
            out_next.pc_minus1 = lat_pcm1_reg;
            if (cpu_in.stack_done) begin
               out_next.stack_req = 1'b0;
               out_next.set_imask = 1'b1;
               out_next.vec_fetch = 1'b1;
               out_next.vec_addr  = eia_vec_addr(lat_code_reg);
               state_next         = ST_RUN;
            end
         end
         ST_UNSTACK: begin
            if (cpu_in.stack_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= ST_RESET_VEC;
         out_reg      <= CPU_OUT_RST;
         lat_code_reg <= CODE_RESET;
         lat_pcm1_reg <= 1'b0;
         stack_h_reg  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         out_reg      <= out_next;
         lat_code_reg <= lat_code_next;
         lat_pcm1_reg <= lat_pcm1_next;
         stack_h_reg  <= 1'b0; // high index never pushed
      end
   end

   // apb slave, one wait-free access cycle
   assign setup       = psel && !penable;
   assign access_done = psel && penable && pready_reg;
   assign wr_done     = access_done && pwrite;
   assign rd_done     = access_done && !pwrite;
   assign addr_ok     = (paddr == STAT1_OFF) || (paddr == STAT2_OFF)
                     || (paddr == STAT3_OFF) || (paddr == STAT4_OFF)
                     || (paddr == EVT_OFF) || (paddr == MASK_OFF);
   assign rd_mux = (paddr == STAT1_OFF) ? {24'h0, lvl_req[5:0], 2'b00}
                 : (paddr == STAT2_OFF) ? {24'h0, lvl_req[13:6]}
                 : (paddr == STAT3_OFF) ? {24'h0, lvl_req[21:14]}
                 : (paddr == STAT4_OFF) ? {30'h0, lvl_req[23:22]}
                 : (paddr == EVT_OFF)   ? {29'h0, evt_reg}
                 : (paddr == MASK_OFF)  ? {29'h0, mask_reg}
                 : 32'h0;

   // sticky events: a new event wins over the read clear
   assign evt_next = ((rd_done && paddr == EVT_OFF) ? '0 : evt_reg)
                   | evt_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0;
         evt_reg     <= '0;
         mask_reg    <= MASK_RST;
         irq_reg     <= 1'b0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !addr_ok;
         prdata_reg  <= (setup && !pwrite) ? rd_mux : 32'h0;
         evt_reg     <= evt_next;
         if (wr_done && paddr == MASK_OFF) begin
            mask_reg <= pwdata[EVT_W-1:0];
         end
         irq_reg     <= |(evt_next & mask_reg);
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign cpu_out = out_reg;
   assign stack_h = stack_h_reg;
   assign irq     = irq_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_BOUNDARY_ONLY: assert property (
      $rose(cpu_out.stack_req) |-> $past(cpu_in.instr_done))
      else $error("stacking began outside an instruction end");

   AST_MASK_AFTER_STACK: assert property (
      (state_reg == ST_STACK && cpu_in.stack_done) |=>
      (cpu_out.set_imask && cpu_out.vec_fetch && !cpu_out.stack_req))
      else $error("mask not set after stacking");

   AST_UNSTACK_ON_RETURN: assert property (
      (state_reg == ST_RUN && !cpu_in.instr_done && cpu_in.rti_exec) |=>
      (cpu_out.unstack_req ##1 !cpu_out.unstack_req))
      else $error("return did not unstack once");

   AST_CODE_HELD: assert property (
      (cpu_out.stack_req && state_reg == ST_STACK && !cpu_in.stack_done)
      |=> $stable(cpu_out.vec_code))
      else $error("latched code changed before service");

   AST_SWI_UNMASKED: assert property (
      take_swi |=> (cpu_out.stack_req && cpu_out.vec_code == CODE_SWI
                    && !cpu_out.pc_minus1))
      else $error("software trap not taken with pc");

   AST_MASK_BLOCKS: assert property (
      (run_bnd && !cpu_in.swi_exec && cpu_in.i_mask) |=>
      !cpu_out.stack_req)
      else $error("masked request was taken");

   AST_HW_PRIO: assert property (
      (take_hw && lvl_req[0]) |=>
      (cpu_out.vec_code == CODE_LVL1 && cpu_out.pc_minus1))
      else $error("highest level not chosen");

   AST_VEC_ADDR: assert property (
      cpu_out.vec_fetch |-> cpu_out.vec_addr == eia_vec_addr(cpu_out.vec_code))
      else $error("vector address does not match code");

   AST_RESET_VEC: assert property (
      (state_reg == ST_RESET_VEC && presetn) |=>
      (cpu_out.vec_fetch && cpu_out.vec_code == CODE_RESET))
      else $error("reset vector not fetched first");

   AST_STAT1_READ: assert property (
      (access_done && !pwrite && paddr == STAT1_OFF && $past(setup)) |->
      (prdata[1:0] == 2'b00 && prdata[7:2] == $past(lvl_req[5:0])))
      else $error("status one read mismatch");

   AST_IRQ_LEVEL: assert property (
      ##1 (irq == |($past(evt_next) & $past(mask_reg))))
      else $error("interrupt output mismatch");

   // entry, return and register view checks
   AST_HIGH_INDEX_IDLE: assert property (
      stack_h == 1'b0)
      else $error("high index register was stacked");

   AST_HW_PC_MINUS1: assert property (
      take_hw |=> (cpu_out.stack_req && cpu_out.pc_minus1))
      else $error("hardware entry did not stack pc minus one");

   AST_ENABLE_GATES: assert property (
      (run_bnd && !cpu_in.swi_exec && !hw_valid) |=>
      !cpu_out.stack_req)
      else $error("entry taken with no enabled request");

   AST_UNSTACK_NO_FETCH: assert property (
      (state_reg == ST_UNSTACK) |=>
      (!cpu_out.vec_fetch && !cpu_out.stack_req))
      else $error("fetch or stacking during return");

   AST_SHARED_LEVEL: assert property (
      lvl_req[SPI_LVL_IDX] == (|{spi_grp_flag & spi_grp_en,
         hw_flag[SPI_LVL_IDX-1] & hw_en[SPI_LVL_IDX-1]}))
      else $error("shared level request mismatch");

   AST_STAT2_READ: assert property (
      (access_done && !pwrite && paddr == STAT2_OFF && $past(setup)) |->
      (prdata == {24'h0, $past(lvl_req[13:6])}))
      else $error("status two read mismatch");

   AST_EVT_STICKY: assert property (
      take_hw |=> evt_reg[EVT_HW])
      else $error("hardware entry event not recorded");

   AST_SLVERR_WITH_READY: assert property (
      pslverr |-> pready)
      else $error("error response without ready");

   COV_SWI: cover property (take_swi ##[1:20] cpu_out.set_imask);
   COV_HW: cover property (take_hw ##[1:20] cpu_out.vec_fetch);
   COV_BACK_TO_BACK: cover property (
      cpu_out.unstack_req ##[1:40] take_hw);
   COV_IRQ: cover property ($rose(irq));
   COV_MASKED: cover property (run_bnd && cpu_in.i_mask && hw_valid);
endmodule // eia_top

// ---- include/eia_pkg.sv ----
// Purpose: shared constants and types of the exception interrupt arbiter
// Assumes: one clock, 32-bit apb, 24 maskable priority levels
// Notes:   vector code n selects vector address 16'hFFFE - 2*n
package eia_pkg;
   localparam int NUM_LVL = 24;
   localparam int SPI_GRP = 3;
   localparam int SCI_GRP = 4;
   localparam int SPI_LVL_IDX = 8;
   localparam int SCI_LVL_IDX = 10;

   localparam logic [7:0] STAT1_OFF = 8'h00;
   localparam logic [7:0] STAT2_OFF = 8'h04;
   localparam logic [7:0] STAT3_OFF = 8'h08;
   localparam logic [7:0] STAT4_OFF = 8'h0C;
   localparam logic [7:0] EVT_OFF   = 8'h10;
   localparam logic [7:0] MASK_OFF  = 8'h14;

   localparam int EVT_W   = 3;
   localparam int EVT_SWI = 0;
   localparam int EVT_HW  = 1;
   localparam int EVT_RTI = 2;
   localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

   localparam logic [15:0] VEC_BASE = 16'hFFFE;
   localparam logic [4:0]  CODE_RESET = 5'h00;
   localparam logic [4:0]  CODE_SWI   = 5'h01;
   localparam logic [4:0]  CODE_LVL1  = 5'h02;

   typedef struct packed {
      logic instr_done;
      logic swi_exec;
      logic rti_exec;
      logic stack_done;
      logic i_mask;
   } eia_cpu_in_t;

   typedef struct packed {
      logic        stack_req;
      logic        pc_minus1;
      logic        set_imask;
      logic        unstack_req;
      logic        vec_fetch;
      logic [4:0]  vec_code;
      logic [15:0] vec_addr;
   } eia_cpu_out_t;

   localparam eia_cpu_out_t CPU_OUT_RST = '{
      stack_req: 1'b0, pc_minus1: 1'b0, set_imask: 1'b0,
      unstack_req: 1'b0, vec_fetch: 1'b0, vec_code: 5'h00,
      vec_addr: 16'hFFFE};

   typedef enum logic [1:0] {
      ST_RESET_VEC,
      ST_RUN,
      ST_STACK,
      ST_UNSTACK
   } eia_state_t;

   function automatic logic [15:0] eia_vec_addr(input logic [4:0] code);
      eia_vec_addr = VEC_BASE - {10'h000, code, 1'b0};
   endfunction
endpackage

// ---- core/eia_prio_enc.sv ----
// Purpose: fixed priority encoder, lowest index wins
// Assumes: req bit 0 is the highest priority
// Notes:   idx is zero when nothing is pending
module eia_prio_enc #(
   parameter int N  = 24,
   parameter int IW = 5
) (
   input  wire logic [N-1:0]  req,
   output logic               valid,
   output logic [IW-1:0]      idx
);
   always_comb begin
      valid = 1'b0;
      idx   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            idx   = IW'(i);
         end
      end
   end
endmodule // eia_prio_enc

// ---- tb/eia_cpu_model.sv ----
// Purpose: cpu core model, answers stacking and keeps the global mask
// Assumes: stack_req is a level, unstack_req a one-cycle pulse
// Notes:   dly sets how many cycles stacking or unstacking takes
module eia_cpu_model
   import eia_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire eia_cpu_out_t cpu_out,
   input  wire logic [3:0]   dly,
   input  wire logic         clr_mask,
   output logic              stk_done,
   output logic              i_mask
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_reg;
   logic       busy_reg;
   wire        start = (cpu_out.stack_req & ~busy_reg & ~stk_done)
                       | cpu_out.unstack_req;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 4'h0;
         busy_reg <= 1'b0;
         stk_done <= 1'b0;
         i_mask <= 1'b0;
      end else begin
         stk_done <= busy_reg & (cnt_reg == 4'h0);
         if (start) begin
            busy_reg <= 1'b1;
            cnt_reg <= dly;
         end else if (busy_reg) begin
            busy_reg <= (cnt_reg != 4'h0);
            cnt_reg <= cnt_reg - 4'h1;
         end
         if (cpu_out.set_imask)
            i_mask <= 1'b1;
         else if (cpu_out.unstack_req | clr_mask)
            i_mask <= 1'b0;
      end
   end
endmodule // eia_cpu_model

// ---- tb/exception_interrupt_arbiter_tb.sv ----
// Purpose: self-checking bench of the exception interrupt arbiter
// Assumes: cpu model answers stacking, bench drives the instruction strobes
// Notes:   status and vector cases run from a row table
module exception_interrupt_arbiter_tb;
   import eia_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int l; logic [7:0] off; int b; logic [15:0] vec;} eia_row_t;
   eia_row_t rows[10] = '{'{1, 8'h00, 2, 16'hFFFA}, '{6, 8'h00, 7, 16'hFFF0},
      '{7, 8'h04, 0, 16'hFFEE}, '{9, 8'h04, 2, 16'hFFEA},
      '{11, 8'h04, 4, 16'hFFE6}, '{14, 8'h04, 7, 16'hFFE0},
      '{15, 8'h08, 0, 16'hFFDE}, '{22, 8'h08, 7, 16'hFFD0},
      '{23, 8'h0C, 0, 16'hFFCE}, '{24, 8'h0C, 1, 16'hFFCC}};
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        irq_pin_n = 1, instr_done = 0, swi_exec = 0, rti_exec = 0;
   logic        clr_mask = 0, stk_done, i_mask, pready, pslverr, stack_h, irq;
   logic        vf, pcm, err, pin_en = 1;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [22:0] hw_flag = 0, hw_en = '1;
   logic [2:0]  spi_f = 0, spi_e = 3'h7;
   logic [3:0]  sci_f = 0, dly = 1, sci_e = 4'hF;
   eia_cpu_out_t cpu_out;
   int          fails = 0, total_checks = 0;
   always #5 pclk = ~pclk;
   eia_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_pin_n(irq_pin_n), .irq_pin_en(pin_en), .hw_flag(hw_flag),
      .hw_en(hw_en), .spi_grp_flag(spi_f), .spi_grp_en(spi_e),
      .sci_grp_flag(sci_f), .sci_grp_en(sci_e), .cpu_out(cpu_out),
      .cpu_in({instr_done, swi_exec, rti_exec, stk_done, i_mask}),
      .stack_h(stack_h), .irq(irq));
   eia_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .cpu_out(cpu_out),
      .dly(dly), .clr_mask(clr_mask), .stk_done(stk_done), .i_mask(i_mask));
   task chk(input logic [32:0] got, input logic [32:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20) chk(0, 1, "apb wait");
   endtask
   task set_lvl(input int l, input logic v);
      if (l == 1) irq_pin_n <= ~v;
      else if (l == 9) spi_f <= {v, 2'h0};
      else if (l == 11) sci_f <= {1'h0, v, 2'h0};
      else hw_flag[l-2] <= v;
   endtask
   task go(input logic s, input logic r);
      @(posedge pclk);
      instr_done <= ~r;
      swi_exec <= s;
      rti_exec <= r;
      @(posedge pclk);
      instr_done <= 0;
      swi_exec <= 0;
      rti_exec <= 0;
   endtask
   task fin(input logic r);
      int n;
      n = 0;
      pcm = 0;
      do begin
         @(posedge pclk);
         n++;
         if (cpu_out.stack_req === 1'b1) pcm = cpu_out.pc_minus1;
         if (stack_h !== 1'b0) chk(stack_h, 0, "high index stacked");
         vf = (cpu_out.vec_fetch === 1'b1);
      end while (!vf && !(r && stk_done === 1'b1) && n < 30);
   endtask
   task take(input logic s, input logic [15:0] va, input logic pm);
      go(s, 0);
      fin(0);
      chk(vf, 1, "no vector fetch");
      chk(cpu_out.vec_addr, va, "vector");
      chk(pcm, pm, "pc stacking kind");
   endtask
   task return_from_handler_instruction;
      go(0, 1);
      fin(1);
      chk(i_mask, 0, "mask after return");
   endtask
   initial begin
      #200000;
      fails++;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      fin(0);
      chk(vf, 1, "reset fetch");
      chk({cpu_out.vec_code, cpu_out.vec_addr}, 21'h0FFFE, "reset vec");
      $display("test reset done");
      foreach (rows[i]) begin
         set_lvl(rows[i].l, 1);
         repeat (2) @(posedge pclk);
         apb(0, rows[i].off, 0);
         chk(rd, 32'h1 << rows[i].b, "status flag");
         take(0, rows[i].vec, 1);
         set_lvl(rows[i].l, 0);
         return_from_handler_instruction();
      end
      $display("test rows done");
      dly <= 6;
      set_lvl(5, 1);
      set_lvl(3, 1);
      go(0, 0);
      set_lvl(2, 1);
      fin(0);
      chk(cpu_out.vec_addr, 16'hFFF6, "pre-empted");
      go(0, 0);
      fin(0);
      chk(vf, 0, "taken while masked");
      return_from_handler_instruction();
      take(0, 16'hFFF8, 1);
      take(1, 16'hFFFC, 0);
      chk(cpu_out.vec_code, 5'h01, "swi code");
      set_lvl(2, 0);
      set_lvl(3, 0);
      set_lvl(5, 0);
      return_from_handler_instruction();
      dly <= 1;
      hw_en[2] <= 0;
      set_lvl(4, 1);
      go(0, 0);
      fin(0);
      chk(vf, 0, "disabled source taken");
      set_lvl(4, 0);
      hw_en[2] <= 1;
      $display("test arbitration done");
      pin_en <= 0;
      spi_e <= 3'h3;
      sci_e <= 4'hB;
      set_lvl(1, 1);
      set_lvl(9, 1);
      set_lvl(11, 1);
      apb(0, STAT1_OFF, 0);
      chk(rd, 32'h0, "pin enable off");
      apb(0, STAT2_OFF, 0);
      chk(rd, 32'h0, "group enables off");
      pin_en <= 1;
      spi_e <= 3'h7;
      sci_e <= 4'hF;
      apb(0, STAT1_OFF, 0);
      chk(rd, 32'h4, "pin enable on");
      apb(0, STAT2_OFF, 0);
      chk(rd, 32'h14, "group enables on");
      set_lvl(1, 0);
      set_lvl(9, 0);
      set_lvl(11, 0);
      apb(1, MASK_OFF, 32'h7);
      repeat (2) @(posedge pclk);
      chk(irq, 1, "irq level");
      apb(0, EVT_OFF, 0);
      chk(rd, 32'h7, "event bits");
      apb(0, EVT_OFF, 0);
      chk(rd, 32'h0, "event clear");
      chk(irq, 0, "irq after clear");
      apb(0, MASK_OFF, 0);
      chk(rd, 32'h7, "mask readback");
      apb(1, STAT1_OFF, 32'hFF);
      apb(0, STAT1_OFF, 0);
      chk({err, rd}, 33'h0, "status write");
      apb(0, 8'h18, 0);
      chk({err, rd}, 33'h100000000, "unmapped");
      $display("test registers done");
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      fin(0);
      chk({vf, cpu_out.vec_addr}, 17'h1FFFE, "vector after reset");
      apb(0, MASK_OFF, 0);
      chk(rd, 32'h0, "mask after reset");
      $display("test mid reset done");
      complete_run;
   end
endmodule // exception_interrupt_arbiter_tb
